//--- src/cvr_pkg.sv
// constants for the cell voltage result register bank
package cvr_pkg;

    // ------------------------------------------------------------
    // result geometry
    // ------------------------------------------------------------
    localparam int          NUM_CELLS     = 5;
    localparam int          CODE_W        = 14;
    localparam int          REG_W         = 16;
    localparam int          CODE_LSB      = 2;
    localparam int          CODE_MSB      = 15;
    localparam int          CELL_SEL_W    = 3;
    // full-scale code is a differential 5 V input on the cell channel
    localparam int          FULL_SCALE_MV = 5000;
    localparam logic [13:0] CODE_RESET    = 14'h0000;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 32;
    localparam int          IDX_W         = 8;
    // printed offsets are register indices; byte address is index * 4
    localparam logic [7:0]  IDX_CELL_FIVE  = 8'h4B;
    localparam logic [7:0]  IDX_CELL_SIX   = 8'h4C;
    localparam logic [7:0]  IDX_CELL_SEVEN = 8'h4D;
    localparam logic [7:0]  IDX_CELL_EIGHT = 8'h4E;
    localparam logic [7:0]  IDX_CELL_NINE  = 8'h4F;
    localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : cvr_pkg

//--- src/cvr_store_if.sv
// carrier between the bus front end and the result store
`timescale 1ns/1ps
`default_nettype none
interface cvr_store_if;
    logic                                                upd_valid;
    logic [cvr_pkg::CELL_SEL_W-1:0]                      upd_cell;
    logic                                                upd_skipped;
    logic [cvr_pkg::CODE_W-1:0]                          upd_avg;
    logic [cvr_pkg::CODE_W-1:0]                          upd_iir;
    logic [cvr_pkg::NUM_CELLS-1:0]                       chan_enable;
    logic                                                filter_sel;
    logic [cvr_pkg::NUM_CELLS-1:0][cvr_pkg::CODE_W-1:0] rd_code;

    modport front (output upd_valid, upd_cell, upd_skipped, upd_avg, upd_iir,
                   output chan_enable, filter_sel, input rd_code);
    modport store (input upd_valid, upd_cell, upd_skipped, upd_avg, upd_iir,
                   input chan_enable, filter_sel, output rd_code);
endinterface : cvr_store_if
`default_nettype wire

//--- src/cvr_cell_store.sv
// per-cell result storage for both readback paths
`timescale 1ns/1ps
`default_nettype none
module cvr_cell_store (
    input  wire logic  ref_clk_i,     // core clock
    input  wire logic  srst_i,        // sync reset, high
    cvr_store_if.store bus_if         // update and readback
);

    typedef struct packed {
        logic [cvr_pkg::NUM_CELLS-1:0][cvr_pkg::CODE_W-1:0] avg;
        logic [cvr_pkg::NUM_CELLS-1:0][cvr_pkg::CODE_W-1:0] iir;
    } cvr_store_t;

    cvr_store_t st_reg;
    cvr_store_t st_next;
    logic       keep_old;

    // ------------------------------------------------------------
    // update
    // ------------------------------------------------------------
    always_comb begin
        st_next  = st_reg;
        keep_old = ~bus_if.chan_enable[bus_if.upd_cell] & bus_if.upd_skipped;
        if (bus_if.upd_valid && (bus_if.upd_cell < 3'(cvr_pkg::NUM_CELLS)) && !keep_old) begin
            st_next.avg[bus_if.upd_cell] = bus_if.upd_avg;
            st_next.iir[bus_if.upd_cell] = bus_if.upd_iir;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // readback source
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < cvr_pkg::NUM_CELLS; g++) begin : g_rd
            // stored path picked live, so a skipped cell shows the chosen filter
            assign bus_if.rd_code[g] = bus_if.filter_sel ? st_reg.iir[g] : st_reg.avg[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_skip_holds: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        bus_if.upd_valid && keep_old |=> st_reg == $past(st_reg))
        else $error("skipped disabled cell changed");
    a_update_stores: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        bus_if.upd_valid && !keep_old && bus_if.upd_cell == 3'h0
        |=> st_reg.avg[0] == $past(bus_if.upd_avg) && st_reg.iir[0] == $past(bus_if.upd_iir))
        else $error("enabled cell result not stored");
    a_filter_path: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !bus_if.upd_valid ##1 bus_if.filter_sel |-> bus_if.rd_code[1] == $past(st_next.iir[1]))
        else $error("readback not from selected path");

endmodule : cvr_cell_store
`default_nettype wire

//--- src/cvr_cell_result_regs.sv
// cell five to nine voltage result registers behind an avalon-mm slave
// ----------------------------------------------------------------
// Functional notes
// - 14-bit code sits in bits 15:2, msb first
// - code full scale equals 5 V differential
// - disabled skipped cell keeps its stored result
// - skipped cell readback uses selected filter path
// - five consecutive read-only registers; writes ignored
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cvr_cell_result_regs (
    input  wire logic                          ref_clk_i,                // core clock, 100 MHz
    input  wire logic                          srst_i,                   // sync reset, high
    // avalon-mm slave
    input  wire logic [cvr_pkg::ADDR_W-1:0]    avs_address_i,            // byte address
    input  wire logic                          avs_read_i,               // read request
    input  wire logic                          avs_write_i,              // write request
    input  wire logic [cvr_pkg::DATA_W-1:0]    avs_writedata_i,          // write data, discarded
    input  wire logic [3:0]                    avs_byteenable_i,         // byte lanes, discarded
    output logic      [cvr_pkg::DATA_W-1:0]    avs_readdata_o,           // read data
    output logic                               avs_waitrequest_o,        // stall
    output logic      [1:0]                    avs_response_o,           // okay or slave error
    // measurement scan results
    input  wire logic                          meas_valid_i,             // one-cycle result strobe
    input  wire logic [cvr_pkg::CELL_SEL_W-1:0] meas_cell_i,             // 0 = cell five .. 4 = nine
    input  wire logic                          meas_skipped_i,           // cell skipped this scan
    input  wire logic [cvr_pkg::CODE_W-1:0]    meas_avg_code_i,          // averaged result code
    input  wire logic [cvr_pkg::CODE_W-1:0]    meas_iir_code_i,          // iir filtered code
    input  wire logic [cvr_pkg::NUM_CELLS-1:0] cell_channel_enable_i,    // per-cell enable
    input  wire logic                          readback_filter_select_i  // 1 = iir, 0 = average
);

    // ----------------------------------------------------------------
    // types and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                       ack;
        logic [cvr_pkg::DATA_W-1:0] rdata;
        logic [1:0]                 resp;
    } cvr_bus_t;

    cvr_bus_t st_reg;
    cvr_bus_t st_next;

    logic                                req;
    logic                                hit;
    logic [cvr_pkg::CELL_SEL_W-1:0]      slot;
    logic [cvr_pkg::CODE_W-1:0]          code_sel;

    cvr_store_if store_if ();

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // returns {hit, slot}; slot 0 is cell five
    function automatic logic [cvr_pkg::CELL_SEL_W:0] cvr_decode(
        input logic [cvr_pkg::ADDR_W-1:0] addr
    );
        logic [cvr_pkg::IDX_W-1:0] idx;
        logic [cvr_pkg::IDX_W-1:0] off;
        idx = addr[cvr_pkg::ADDR_W-1:2];
        off = idx - cvr_pkg::IDX_CELL_FIVE;
        if ((idx >= cvr_pkg::IDX_CELL_FIVE) && (idx <= cvr_pkg::IDX_CELL_NINE)) begin
            return {1'b1, off[cvr_pkg::CELL_SEL_W-1:0]};
        end
        return '0;
    endfunction : cvr_decode

    assign {hit, slot} = cvr_decode(avs_address_i);
    assign code_sel    = store_if.rd_code[slot];

    // ----------------------------------------------------------------
    // result store
    // ----------------------------------------------------------------
    // the store takes scan results only; the bus has no write path into it
    assign store_if.upd_valid   = meas_valid_i;
    assign store_if.upd_cell    = meas_cell_i;
    assign store_if.upd_skipped = meas_skipped_i;
    assign store_if.upd_avg     = meas_avg_code_i;
    assign store_if.upd_iir     = meas_iir_code_i;
    assign store_if.chan_enable = cell_channel_enable_i;
    assign store_if.filter_sel  = readback_filter_select_i;

    cvr_cell_store u_store (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .bus_if    (store_if)
    );

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait state: data is latched in the first cycle, released in the second
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~st_reg.ack;
    assign avs_readdata_o    = st_reg.rdata;
    assign avs_response_o    = st_reg.resp;

    always_comb begin
        st_next     = st_reg;
        st_next.ack = req & ~st_reg.ack;
        if (req && !st_reg.ack) begin
            st_next.resp = hit ? cvr_pkg::RESP_OKAY : cvr_pkg::RESP_SLVERR;
        end
        if (avs_read_i && !st_reg.ack) begin
            st_next.rdata = cvr_pkg::RDATA_RESET;
            if (hit) begin
                // code left-justified, bits 1:0 and upper half stay zero
                st_next.rdata[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB] = code_sel;
            end
        end
        // writes complete normally but store nothing: result registers are read only
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_low_bits_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        avs_readdata_o[1:0] == 2'h0 && avs_readdata_o[31:16] == 16'h0000)
        else $error("unused read data bits not zero");

    a_code_justified: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        avs_read_i && hit && !avs_waitrequest_o
        |-> avs_readdata_o[15:2] == $past(code_sel))
        else $error("cell code not in bits 15:2");

    a_write_ignored: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        avs_write_i && !meas_valid_i ##1 $stable(readback_filter_select_i)
        |-> store_if.rd_code == $past(store_if.rd_code))
        else $error("host write changed a result");

    a_unmapped_err: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        req && !avs_waitrequest_o |-> avs_response_o == (hit ? 2'h0 : 2'h2))
        else $error("wrong response for address");

    a_reset_clear: assert property (@(posedge ref_clk_i)
        srst_i ##1 !srst_i |-> avs_readdata_o == 32'h0000_0000 && store_if.rd_code == '0)
        else $error("registers not zero after reset");

    a_one_wait: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        req && avs_waitrequest_o && $stable(avs_address_i) ##1 req |-> !avs_waitrequest_o)
        else $error("slave stalled more than one cycle");

    // ----------------------------------------------------------------
    // standing outputs and bus answers
    // ----------------------------------------------------------------
    // read data only moves on the first cycle of a read; writes leave it alone
    a_rdata_stands: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !(avs_read_i && !st_reg.ack) |=> $stable(avs_readdata_o))
        else $error("read data moved without a read");

    a_first_stall: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $rose(req) |-> avs_waitrequest_o)
        else $error("request not stalled in its first cycle");

    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        avs_read_i && !hit && !avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    // top code is the 5 V point and must fill bits 15:2 exactly
    a_full_scale: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        avs_read_i && hit && !avs_waitrequest_o && $past(code_sel) == 14'h3FFF
        |-> avs_readdata_o[15:0] == 16'hFFFC)
        else $error("full-scale code misplaced");

    a_reset_resp: assert property (@(posedge ref_clk_i)
        srst_i ##1 !srst_i |-> avs_response_o == 2'h0)
        else $error("bus response not idle after reset");

    // ----------------------------------------------------------------
    // per-cell checks
    // ----------------------------------------------------------------
    // address compared directly, so a slip in the decode function shows here
    logic [cvr_pkg::NUM_CELLS-1:0] cell_read_done;

    genvar c;
    generate
        for (c = 0; c < cvr_pkg::NUM_CELLS; c++) begin : g_cell_chk
            assign cell_read_done[c] = avs_read_i && !avs_waitrequest_o
                && (avs_address_i[cvr_pkg::ADDR_W-1:2] == cvr_pkg::IDX_CELL_FIVE + 8'(c));

            a_cell_word: assert property (@(posedge ref_clk_i) disable iff (srst_i)
                cell_read_done[c]
                |-> avs_readdata_o == {16'h0000, $past(store_if.rd_code[c]), 2'b00})
                else $error("cell word read from wrong slot");

            a_cell_update: assert property (@(posedge ref_clk_i) disable iff (srst_i)
                meas_valid_i && meas_cell_i == 3'(c)
                && (cell_channel_enable_i[c] || !meas_skipped_i)
                |=> store_if.rd_code[c] == (readback_filter_select_i ? $past(meas_iir_code_i)
                                                                     : $past(meas_avg_code_i)))
                else $error("scan result not stored for cell");

            a_cell_skip_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
                meas_valid_i && meas_cell_i == 3'(c)
                && !cell_channel_enable_i[c] && meas_skipped_i
                ##1 $stable(readback_filter_select_i)
                |-> $stable(store_if.rd_code[c]))
                else $error("skipped disabled cell changed a result");

            // stored pair read from the store's own flops, not through the readback mux
            a_cell_iir_path: assert property (@(posedge ref_clk_i) disable iff (srst_i)
                cell_read_done[c] && $past(readback_filter_select_i)
                |-> avs_readdata_o[15:2] == $past(u_store.st_reg.iir[c]))
                else $error("filtered path not returned for cell");

            a_cell_avg_path: assert property (@(posedge ref_clk_i) disable iff (srst_i)
                cell_read_done[c] && !$past(readback_filter_select_i)
                |-> avs_readdata_o[15:2] == $past(u_store.st_reg.avg[c]))
                else $error("averaged path not returned for cell");
        end
    endgenerate

endmodule : cvr_cell_result_regs
`default_nettype wire

//--- dv/cvr_cell_result_regs_tb.sv
// self-checking bench for the cell voltage result register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module cvr_cell_result_regs_tb;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic                              ref_clk_i = 1'b0;
    logic                              srst_i    = 1'b1;
    logic [cvr_pkg::ADDR_W-1:0]        avs_address_i = '0;
    logic                              avs_read_i    = 1'b0;
    logic                              avs_write_i   = 1'b0;
    logic [cvr_pkg::DATA_W-1:0]        avs_writedata_i = '0;
    logic [cvr_pkg::DATA_W-1:0]        avs_readdata_o;
    logic                              avs_waitrequest_o;
    logic [1:0]                        avs_response_o;
    logic                              meas_valid_i   = 1'b0;
    logic [cvr_pkg::CELL_SEL_W-1:0]    meas_cell_i    = '0;
    logic                              meas_skipped_i = 1'b0;
    logic [cvr_pkg::CODE_W-1:0]        meas_avg_code_i = '0;
    logic [cvr_pkg::CODE_W-1:0]        meas_iir_code_i = '0;
    logic [cvr_pkg::NUM_CELLS-1:0]     enable = 5'h1F;
    logic                              fsel   = 1'b0;
    logic [cvr_pkg::CODE_W-1:0]        exp_avg [5];
    logic [cvr_pkg::CODE_W-1:0]        exp_iir [5];
    logic [31:0]                       rd;
    logic [1:0]                        rs;
    int                                fail_count = 0;
    int                                checked    = 0;
    int                                cyc        = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    cvr_cell_result_regs u_cvr_cell_result_regs (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .meas_valid_i(meas_valid_i),
        .meas_cell_i(meas_cell_i), .meas_skipped_i(meas_skipped_i),
        .meas_avg_code_i(meas_avg_code_i), .meas_iir_code_i(meas_iir_code_i),
        .cell_channel_enable_i(enable), .readback_filter_select_i(fsel));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // request held until the edge that sees waitrequest low
    task automatic bus_xfer(input bit wr, input logic [9:0] a, input logic [31:0] wd);
        avs_address_i   <= a;
        avs_writedata_i <= wd;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        rs = avs_response_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : bus_xfer

    function automatic logic [9:0] cell_addr(input int i);
        return {cvr_pkg::IDX_CELL_FIVE + 8'(i), 2'b00};
    endfunction : cell_addr

    task automatic rd_chk(input int i, input logic [13:0] code);
        bus_xfer(1'b0, cell_addr(i), 32'h0000_0000);
        `CHK(rd, {16'h0000, code, 2'b00})
        `CHK(rs, cvr_pkg::RESP_OKAY)
    endtask : rd_chk

    task automatic rd_all();
        // a filter select set in this time step must land before expectations are picked
        @(posedge ref_clk_i);
        for (int i = 0; i < 5; i++)
            rd_chk(i, fsel ? exp_iir[i] : exp_avg[i]);
    endtask : rd_all

    // disabled and skipped leaves the stored pair alone
    task automatic meas(input int c, input bit sk, input logic [13:0] av, iv);
        meas_valid_i <= 1'b1;
        meas_cell_i <= 3'(c);
        meas_skipped_i <= sk;
        meas_avg_code_i <= av;
        meas_iir_code_i <= iv;
        // judged at the sampling edge, after any enable change has landed
        @(posedge ref_clk_i);
        if (c < 5 && !(enable[c % 5] == 1'b0 && sk)) begin
            exp_avg[c] = av;
            exp_iir[c] = iv;
        end
        meas_valid_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : meas

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        for (int i = 0; i < 5; i++) begin
            exp_avg[i] = 14'h0000;
            exp_iir[i] = 14'h0000;
        end
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd_all();
        for (int i = 0; i < 4; i++)
            meas(i, 1'b0, 14'(14'h0A5D + i * 14'h0713), 14'(14'h2C36 - i * 14'h0521));
        meas(4, 1'b0, 14'h3FFF, 14'h0001);
        rd_all();
        rd_chk(4, 14'h3FFF);
        fsel <= 1'b1;
        rd_all();
        for (int i = 0; i < 5; i++) begin
            bus_xfer(1'b1, cell_addr(i), 32'hFFFF_FFFF);
            `CHK(rs, cvr_pkg::RESP_OKAY)
        end
        rd_all();
        bus_xfer(1'b0, 10'h140, 32'h0000_0000);
        `CHK(rs, cvr_pkg::RESP_SLVERR)
        `CHK(rd, 32'h0000_0000)
        bus_xfer(1'b0, 10'h128, 32'h0000_0000);
        `CHK(rs, cvr_pkg::RESP_SLVERR)
        // out-of-range cell index must not land anywhere
        meas(5, 1'b0, 14'h1234, 14'h1234);
        enable <= 5'h1E;
        meas(0, 1'b1, 14'h1111, 14'h2222);
        rd_all();
        fsel <= 1'b0;
        rd_all();
        meas(1, 1'b1, 14'h0333, 14'h0444);
        meas(0, 1'b0, 14'h0555, 14'h0666);
        rd_all();
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (int i = 0; i < 5; i++)
            rd_chk(i, 14'h0000);
        finish_test();
    end
endmodule : cvr_cell_result_regs_tb
`undef CHK
`default_nettype wire
